/* caul_cfg.svh */
`ifndef CAUL_CFG_SVH
`define CAUL_CFG_SVH

// Channel count and data width
`define CAUL_NUM_CH 8
`define CAUL_DATA_W 32

// Alarm vector bit positions
`define CAUL_ALM_LL 0
`define CAUL_ALM_L 1
`define CAUL_ALM_H 2
`define CAUL_ALM_HH 3
`define CAUL_ALM_RATE 4
`define CAUL_ALM_W 5

// Reset values
`define CAUL_DATA_RST 32'h0000_0000

`endif

/* caul_channel_ctrl.sv */
`include "caul_cfg.svh"
`timescale 1ns/10ps
`default_nettype none

module caul_channel_ctrl #(
  parameter bit CAL_VARIANT = 1'b1
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Update cycle strobe and connection state
  input wire logic tag_update,
  input wire logic connection_open,
  // Output tag bits
  input wire logic low_low_alarm_clear,
  input wire logic low_level_alarm_clear,
  input wire logic high_level_alarm_clear,
  input wire logic high_high_alarm_clear,
  input wire logic rate_alarm_clear,
  input wire logic [`CAUL_ALM_W-2:0] level_alarm_enable,
  input wire logic rate_alarm_enable,
  input wire logic calibrate,
  input wire logic low_point_trigger,
  input wire logic high_point_trigger,
  input wire logic [`CAUL_DATA_W-1:0] sensor_offset_value,
  // Configuration
  input wire logic channel_alarms_off,
  // Alarm detection results
  input wire logic [`CAUL_ALM_W-1:0] alarm_detect,
  // Measurement
  input wire logic [`CAUL_DATA_W-1:0] measured_value,
  // Alarm and calibration status
  output logic [`CAUL_ALM_W-1:0] alarm_latched,
  output logic [`CAUL_ALM_W-1:0] alarm_active_enable,
  output logic calibrating,
  output logic low_point_cal_pulse,
  output logic high_point_cal_pulse,
  output logic calibration_done_flag,
  output logic calibration_failed,
  // Scaled data
  output logic [`CAUL_DATA_W-1:0] scaled_data
);

  logic [`CAUL_ALM_W-1:0] clr_prev_reg;
  logic [`CAUL_ALM_W-1:0] clr_prev_next;
  logic [`CAUL_ALM_W-1:0] alarm_reg;
  logic [`CAUL_ALM_W-1:0] alarm_next;
  logic [`CAUL_ALM_W-1:0] clr_now;
  logic [`CAUL_ALM_W-1:0] clr_rise;
  logic [`CAUL_ALM_W-1:0] enable_vec;

  logic low_prev_reg;
  logic low_prev_next;
  logic high_prev_reg;
  logic high_prev_next;
  logic low_rise;
  logic high_rise;
  logic low_trig_eff;
  logic high_trig_eff;
  caul_pkg::caul_cal_state_t cal_state_reg;
  caul_pkg::caul_cal_state_t cal_state_next;
  logic done_reg;
  logic done_next;
  logic fail_reg;
  logic fail_next;
  logic low_pulse_reg;
  logic low_pulse_next;
  logic high_pulse_reg;
  logic high_pulse_next;
  caul_pkg::caul_word_t data_reg;
  caul_pkg::caul_word_t data_next;

  // Trigger bits are not present in the plain data variant
  assign low_trig_eff = CAL_VARIANT & low_point_trigger;
  assign high_trig_eff = CAL_VARIANT & high_point_trigger;

  always_comb begin
    clr_now = '0;
    clr_now[`CAUL_ALM_LL] = low_low_alarm_clear;
    clr_now[`CAUL_ALM_L] = low_level_alarm_clear;
    clr_now[`CAUL_ALM_H] = high_level_alarm_clear;
    clr_now[`CAUL_ALM_HH] = high_high_alarm_clear;
    clr_now[`CAUL_ALM_RATE] = rate_alarm_clear;
  end

  // Edges are judged only on update boundaries
  assign clr_rise = tag_update ? (clr_now & ~clr_prev_reg) : '0;
  assign low_rise = tag_update & low_trig_eff & ~low_prev_reg;
  assign high_rise = tag_update & high_trig_eff & ~high_prev_reg;

  always_comb begin
    enable_vec[`CAUL_ALM_W-2:0] = level_alarm_enable & {(`CAUL_ALM_W-1){~channel_alarms_off}};
    enable_vec[`CAUL_ALM_RATE] = rate_alarm_enable & ~channel_alarms_off;
  end

  // Alarm latches: the unlatch edge wins only over an already held alarm; new detection
  // in the same cycle sets again so no event is lost
  always_comb begin
    clr_prev_next = tag_update ? clr_now : clr_prev_reg;
    alarm_next = (alarm_reg & ~clr_rise) | (alarm_detect & enable_vec);
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      clr_prev_reg <= '0;
      alarm_reg <= '0;
    end else begin
      clr_prev_reg <= clr_prev_next;
      alarm_reg <= alarm_next;
    end
  end

  // Calibration sequence
  always_comb begin
    cal_state_next = cal_state_reg;
    done_next = done_reg & connection_open;
    fail_next = fail_reg;
    low_pulse_next = 1'b0;
    high_pulse_next = 1'b0;
    low_prev_next = tag_update ? low_trig_eff : low_prev_reg;
    high_prev_next = tag_update ? high_trig_eff : high_prev_reg;
    case (cal_state_reg)
      caul_pkg::CAUL_CAL_IDLE: begin
        if (tag_update && calibrate && CAL_VARIANT) begin
          cal_state_next = caul_pkg::CAUL_CAL_WAIT_LOW;
          done_next = 1'b0;
          fail_next = 1'b0;
        end
      end
      caul_pkg::CAUL_CAL_WAIT_LOW: begin
        if (tag_update && !calibrate) begin
          cal_state_next = caul_pkg::CAUL_CAL_IDLE;
          fail_next = 1'b1;
        end else if (low_rise) begin
          low_pulse_next = 1'b1;
          cal_state_next = caul_pkg::CAUL_CAL_WAIT_HIGH;
        end
      end
      caul_pkg::CAUL_CAL_WAIT_HIGH: begin
        if (tag_update && !calibrate) begin
          cal_state_next = caul_pkg::CAUL_CAL_IDLE;
          fail_next = 1'b1;
        end else if (high_rise) begin
          high_pulse_next = 1'b1;
          cal_state_next = caul_pkg::CAUL_CAL_FINISH;
        end
      end
      caul_pkg::CAUL_CAL_FINISH: begin
        // Calibrating state is exited once the calibrate bit is released
        if (tag_update && !calibrate) begin
          cal_state_next = caul_pkg::CAUL_CAL_IDLE;
          done_next = connection_open;
        end
      end
      default: begin
        cal_state_next = caul_pkg::CAUL_CAL_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cal_state_reg <= caul_pkg::CAUL_CAL_IDLE;
      done_reg <= 1'b0;
      fail_reg <= 1'b0;
      low_pulse_reg <= 1'b0;
      high_pulse_reg <= 1'b0;
      low_prev_reg <= 1'b0;
      high_prev_reg <= 1'b0;
    end else begin
      cal_state_reg <= cal_state_next;
      done_reg <= done_next;
      fail_reg <= fail_next;
      low_pulse_reg <= low_pulse_next;
      high_pulse_reg <= high_pulse_next;
      low_prev_reg <= low_prev_next;
      high_prev_reg <= high_prev_next;
    end
  end

  // Scaled data, refreshed once per update
  always_comb begin
    data_next = data_reg;
    if (tag_update) begin
      // Carry out of the top bit is dropped on purpose: the sum wraps
      data_next = `CAUL_DATA_W'(measured_value + sensor_offset_value);
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      data_reg <= `CAUL_DATA_RST;
    end else begin
      data_reg <= data_next;
    end
  end

  assign alarm_latched = alarm_reg;
  assign alarm_active_enable = enable_vec;
  assign calibrating = (cal_state_reg != caul_pkg::CAUL_CAL_IDLE);
  assign low_point_cal_pulse = low_pulse_reg;
  assign high_point_cal_pulse = high_pulse_reg;
  assign calibration_done_flag = done_reg;
  assign calibration_failed = fail_reg;
  assign scaled_data = data_reg;

endmodule : caul_channel_ctrl

`default_nettype wire

/* caul_channel_ctrl_props.sv */
`timescale 1ns/10ps
`default_nettype none
module caul_channel_ctrl_props (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Tag and data inputs
  input wire logic tag_update,
  input wire logic connection_open,
  input wire logic low_low_alarm_clear,
  input wire logic rate_alarm_clear,
  input wire logic [3:0] level_alarm_enable,
  input wire logic rate_alarm_enable,
  input wire logic calibrate,
  input wire logic low_point_trigger,
  input wire logic channel_alarms_off,
  input wire logic [4:0] alarm_detect,
  input wire logic [31:0] measured_value,
  input wire logic [31:0] sensor_offset_value,
  // Outputs
  input wire logic [4:0] alarm_latched,
  input wire logic [4:0] alarm_active_enable,
  input wire logic calibrating,
  input wire logic low_point_cal_pulse,
  input wire logic calibration_done_flag,
  input wire logic calibration_failed,
  input wire logic [31:0] scaled_data
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  logic [2:0] pv;
  // Bit values of the previous update
  always_ff @(posedge clk) begin
    if (tag_update) pv <= {low_point_trigger, rate_alarm_clear, low_low_alarm_clear};
  end
  sequence s_ll_edge;
    tag_update && low_low_alarm_clear && !pv[0] && !alarm_detect[0];
  endsequence
  sequence s_drop;
    calibrating && tag_update && !calibrate;
  endsequence
  a_ll_unlatch: assert property (s_ll_edge |=> !alarm_latched[0])
    else $error("low-low alarm not cleared");
  a_rate_unlatch: assert property (tag_update && rate_alarm_clear && !pv[1]
    && !alarm_detect[4] |=> !alarm_latched[4]) else $error("rate alarm not cleared");
  a_latch_hold: assert property (alarm_latched[0] && !tag_update |=> alarm_latched[0])
    else $error("alarm dropped");
  a_enable_gate: assert property (alarm_active_enable ==
    ({rate_alarm_enable, level_alarm_enable} & {5{!channel_alarms_off}})) else $error("enable");
  a_cal_start: assert property (tag_update && calibrate && !calibrating |=> calibrating)
    else $error("calibration not started");
  a_low_step: assert property (low_point_cal_pulse |-> $past(tag_update)
    && $past(low_point_trigger) && !$past(pv[2])) else $error("low pulse");
  a_cal_abort: assert property (s_drop |=> !calibrating
    && (calibration_failed != calibration_done_flag)) else $error("abort");
  a_done_drop: assert property (!connection_open |=> !calibration_done_flag)
    else $error("done kept");
  a_scaled_sum: assert property ($past(tag_update) |-> scaled_data ==
    $past(measured_value) + $past(sensor_offset_value)) else $error("sum");
endmodule : caul_channel_ctrl_props
`default_nettype wire

/* caul_channel_ctrl_tb.sv */
`timescale 1ns/10ps
`default_nettype none
module caul_channel_ctrl_tb;
  logic clk = 1'b0, rst_n = 1'b0, connection_open = 1'b1, channel_alarms_off = 1'b0;
  logic go = 1'b0, upd_q = 1'b0, tag_update, calibrating, low_point_cal_pulse;
  logic high_point_cal_pulse, calibration_done_flag, calibration_failed, rate_alarm_enable;
  logic low_low_alarm_clear, low_level_alarm_clear, high_level_alarm_clear;
  logic high_high_alarm_clear, rate_alarm_clear, calibrate, low_point_trigger;
  logic high_point_trigger;
  logic [8:0] bits_in = 9'h000, bits;
  logic [3:0] level_alarm_enable = 4'hf;
  logic [4:0] alarm_detect = 5'h00, alarm_latched, alarm_active_enable;
  logic [31:0] measured_value = 32'h0, sensor_offset_value = 32'h0, scaled_data;
  logic [31:0] seed = 32'hc813b0dd;
  logic [31:0] sb[$];
  int err_total = 0, check_count = 0, cyc = 0;
  assign {high_point_trigger, low_point_trigger, calibrate, rate_alarm_enable, rate_alarm_clear,
    high_high_alarm_clear, high_level_alarm_clear, low_level_alarm_clear, low_low_alarm_clear} = bits;
  caul_tag_writer u_caul_tag_writer (.clk(clk), .go(go), .bits_in(bits_in),
    .tag_update(tag_update), .bits(bits));
  caul_channel_ctrl u_caul_channel_ctrl (.*);
  always #2 clk = ~clk;
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction : xs
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic print_verdict;
    $display("errors %0d checks %0d", err_total, check_count);
    if (err_total == 0 && check_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : print_verdict
  task automatic upd(input logic [8:0] b);
    @(posedge clk);
    seed = xs(seed);
    go <= 1'b1;
    bits_in <= b;
    measured_value <= seed;
    sensor_offset_value <= xs(seed);
    sb.push_back(seed + xs(seed));
    @(posedge clk);
    go <= 1'b0;
    @(posedge clk);
    @(negedge clk);
  endtask : upd
  always @(posedge clk) upd_q <= tag_update;
  always @(negedge clk) begin
    if (upd_q && sb.size() > 0) chk("scaled", scaled_data, sb.pop_front());
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 2000) begin
      err_total++;
      print_verdict();
    end
  end
  initial begin
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    upd(9'h020);
    for (int i = 0; i < 5; i++) begin
      @(posedge clk);
      alarm_detect <= 5'h01 << i;
      @(posedge clk);
      alarm_detect <= 5'h00;
      upd(9'h020);
      chk("latched", alarm_latched, 32'h1 << i);
      upd(9'h020 | (9'h001 << i));
      chk("latched", alarm_latched, 0);
    end
    for (int i = 0; i < 4; i++) begin
      @(posedge clk);
      seed = xs(seed);
      level_alarm_enable <= seed[3:0];
      channel_alarms_off <= i[0];
      @(negedge clk);
      chk("enable", alarm_active_enable, {1'b1, seed[3:0]} & {5{!i[0]}});
    end
    upd(9'h040);
    chk("calibrating", calibrating, 1);
    upd(9'h0c0);
    chk("low pulse", low_point_cal_pulse, 1);
    upd(9'h1c0);
    chk("high pulse", high_point_cal_pulse, 1);
    upd(9'h000);
    chk("done", calibration_done_flag, 1);
    @(posedge clk);
    connection_open <= 1'b0;
    @(posedge clk);
    connection_open <= 1'b1;
    @(negedge clk);
    chk("done", calibration_done_flag, 0);
    upd(9'h040);
    upd(9'h0c0);
    upd(9'h080);
    chk("failed", calibration_failed, 1);
    chk("low pulse", low_point_cal_pulse, 0);
    print_verdict();
  end
endmodule : caul_channel_ctrl_tb
bind caul_channel_ctrl caul_channel_ctrl_props u_caul_channel_ctrl_props (.*);
`default_nettype wire

/* caul_pkg.sv */
`include "caul_cfg.svh"

package caul_pkg;

  typedef enum logic [3:0] {
    CAUL_CAL_IDLE = 4'h1,
    CAUL_CAL_WAIT_LOW = 4'h2,
    CAUL_CAL_WAIT_HIGH = 4'h4,
    CAUL_CAL_FINISH = 4'h8
  } caul_cal_state_t;

  typedef logic [`CAUL_DATA_W-1:0] caul_word_t;

endpackage : caul_pkg

/* caul_tag_writer.sv */
`timescale 1ns/10ps
`default_nettype none
module caul_tag_writer (
  // Clock and bench request
  input wire logic clk,
  input wire logic go,
  input wire logic [8:0] bits_in,
  // Output tag image
  output logic tag_update,
  output logic [8:0] bits
);
  initial tag_update = 1'b0;
  initial bits = 9'h000;
  // Tag bits hold until the next update
  always @(posedge clk) begin
    tag_update <= go;
    if (go) bits <= bits_in;
  end
endmodule : caul_tag_writer
`default_nettype wire
